// file: rtl/arith_alu.sv
// add, add with carry, subtract with borrow, step up/down and bcd fixup
// assumes purely combinational use; flags follow the usual 8-bit conventions
`timescale 1ns/1ns
`default_nettype none
module arith_alu
    import cpu_arith_pkg::*;
(
    // operation
    input  wire logic [3:0] kind_i,
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] src_i,
    input  wire logic       cy_i,
    input  wire logic       ac_i,
    // result
    output logic      [7:0] res_o,
    output logic            cy_o,
    output logic            ac_o,
    output logic            ov_o
);
    ////////////////////////////////////////////////////////////////////////////
    // subtraction runs as a + ~src + ~borrow so one adder serves all three
    wire       sub = (kind_i == K_SUBW);
    wire       ci  = sub ? ~cy_i : ((kind_i == K_SUMC) & cy_i);
    wire [7:0] bv  = sub ? ~src_i : src_i;
    wire [4:0] lo5 = {1'b0, a_i[3:0]} + {1'b0, bv[3:0]} + {4'h0, ci};
    wire [7:0] s7  = {1'b0, a_i[6:0]} + {1'b0, bv[6:0]} + {7'h00, ci};
    wire [8:0] s8  = {1'b0, a_i} + {1'b0, bv} + {8'h00, ci};
    // bcd fixup works on the accumulator with the current flags
    wire [8:0] d1  = {1'b0, a_i} + (((a_i[3:0] > BCD_MAX[3:0]) || ac_i) ? BCD_LO_ADJ : 9'h000);
    wire       hi_fix = (d1[7:4] > BCD_MAX[3:0]) || cy_i || d1[8];
    wire [8:0] d2  = d1 + (hi_fix ? BCD_HI_ADJ : 9'h000);

    // result and flag select
    always_comb begin
        res_o = s8[7:0];
        cy_o  = cy_i;
        ac_o  = ac_i;
        ov_o  = 1'b0;
        case (kind_i)
            K_ADD, K_SUMC, K_SUBW: begin
                cy_o = s8[8] ^ sub;        // borrow is the inverted carry
                ac_o = lo5[4] ^ sub;
                ov_o = s8[8] ^ s7[7];
            end
            K_INC:   res_o = src_i + 8'h01;
            K_DEC:   res_o = src_i - 8'h01;
            K_DA: begin
                res_o = d2[7:0];
                cy_o  = cy_i | d1[8] | d2[8];
            end
            default: res_o = s8[7:0];
        endcase
    end
endmodule : arith_alu
`default_nettype wire

// file: rtl/cpu_arith_core.sv
// operand addressing and arithmetic execution for the 8-bit core
// assumes a fetch stage presenting whole instructions, data memory answering
// one cycle after its read strobe, and code memory answering the same way
`timescale 1ns/1ns
`default_nettype none
module cpu_arith_core
    import cpu_arith_pkg::*;
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        srst_i,
    // instruction issue
    input  wire logic        inst_valid_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [7:0]  oper1_i,
    input  wire logic [7:0]  oper2_i,
    input  wire logic [1:0]  bank_sel_i,
    output logic             inst_ready_o,
    output logic             done_o,
    output logic             illegal_o,
    // internal ram and special function register port
    output logic      [7:0]  mem_addr_o,
    output logic             mem_rd_o,
    output logic             mem_wr_o,
    output logic      [7:0]  mem_wdata_o,
    input  wire logic [7:0]  mem_rdata_i,
    // program memory read port
    output logic      [15:0] code_addr_o,
    output logic             code_rd_o,
    input  wire logic [7:0]  code_rdata_i,
    // architectural state
    output logic      [7:0]  acc_o,
    output logic      [7:0]  b_o,
    output logic      [15:0] wptr_o,
    output logic             carry_o,
    output logic             aux_carry_o,
    output logic             overflow_o
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

    ////////////////////////////////////////////////////////////////////////////
    // state
    state_e      state_q;
    logic [3:0]  kind_q;
    logic [2:0]  src_q;
    logic [2:0]  ncyc_q;
    logic [2:0]  el_q;
    logic [7:0]  opnd_q;
    logic [7:0]  oper2_q;
    logic [4:0]  idx_q;
    logic [2:0]  bitsel_q;
    logic        fetch_q;
    logic        from_code_q;
    logic        ready_q;
    logic        done_q;
    logic        illegal_q;
    logic [7:0]  mem_addr_q;
    logic        mem_rd_q;
    logic        mem_wr_q;
    logic [7:0]  mem_wdata_q;
    logic [15:0] code_addr_q;
    logic        code_rd_q;
    logic [7:0]  acc_q;
    logic [7:0]  b_q;
    logic [15:0] wptr_q;
    logic        cy_q;
    logic        ac_q;
    logic        ov_q;
    logic [7:0]  rf_q [RF_DEPTH];

    // next values
    logic [7:0]  acc_d;
    logic [7:0]  b_d;
    logic [15:0] wptr_d;
    logic        cy_d;
    logic        ac_d;
    logic        ov_d;
    logic        rf_we;
    logic [7:0]  rf_wdata;
    logic        ready_d;

    // unit results
    logic [7:0]  alu_res;
    logic        alu_cy;
    logic        alu_ac;
    logic        alu_ov;
    logic [15:0] prod;
    logic [7:0]  quot;
    logic [7:0]  rem;
    logic        div_zero;

    ////////////////////////////////////////////////////////////////////////////
    // decode of the offered instruction
    wire [3:0] dec_kind  = op_kind(opcode_i);
    wire [2:0] dec_src   = src_mode(opcode_i);
    wire [2:0] dec_ncyc  = cycles_of(dec_kind, dec_src);
    wire       dec_movc  = (dec_kind == K_MOVC);
    wire       dec_fetch = (dec_src == S_DIR) || (dec_src == S_IND) || dec_movc;
    wire       take      = inst_valid_i & ready_q;

    // pointer for indirect forms; bypass a register write landing this same edge
    wire [4:0] ptr_idx   = rf_index(bank_sel_i, {2'b00, opcode_i[0]});
    wire       ptr_byp   = rf_we && (idx_q == ptr_idx);
    wire [7:0] ptr_val   = ptr_byp ? rf_wdata : rf_q[ptr_idx];
    // data address: bit byte, register pointer or the direct field
    wire [7:0] bit_addr  = bit_byte_addr(oper1_i);
    wire [7:0] dat_addr  = (dec_kind == K_BIT) ? bit_addr :
                           (dec_src == S_IND) ? ptr_val : oper1_i;
    // indexed code address uses the forwarded accumulator and pointer
    wire [15:0] idx_addr = wptr_d + {8'h00, acc_d};

    ////////////////////////////////////////////////////////////////////////////
    // execution phase decode
    wire exec      = (state_q == ST_EXEC);
    wire fin       = exec && (el_q == ncyc_q);
    wire fetch_ph  = exec && fetch_q && (el_q == PH_FETCH);
    wire [7:0] fetch_data = from_code_q ? code_rdata_i : mem_rdata_i;
    wire is_step   = (kind_q == K_INC) || (kind_q == K_DEC);
    wire mem_dst   = (src_q == S_DIR) || (src_q == S_IND);
    wire rmw_wr    = fetch_ph && is_step && mem_dst;
    wire [2:0] el_inc = el_q + PH_FIRST;

    // operand select: fetched byte wins in its own cycle, else the register, the accumulator or the held copy
    wire [7:0] src_val = fetch_ph ? fetch_data :
                         (src_q == S_REG) ? rf_q[idx_q] :
                         (src_q == S_ACC) ? acc_q : opnd_q;

    ////////////////////////////////////////////////////////////////////////////
    // datapath units
    arith_alu u_alu (
        .kind_i (kind_q),
        .a_i    (acc_q),
        .src_i  (src_val),
        .cy_i   (cy_q),
        .ac_i   (ac_q),
        .res_o  (alu_res),
        .cy_o   (alu_cy),
        .ac_o   (alu_ac),
        .ov_o   (alu_ov)
    );

    mul_div_unit u_muldiv (
        .a_i        (acc_q),
        .b_i        (b_q),
        .prod_o     (prod),
        .quot_o     (quot),
        .rem_o      (rem),
        .div_zero_o (div_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // writeback at the final edge of each instruction
    always_comb begin
        acc_d    = acc_q;
        b_d      = b_q;
        wptr_d   = wptr_q;
        cy_d     = cy_q;
        ac_d     = ac_q;
        ov_d     = ov_q;
        rf_we    = 1'b0;
        rf_wdata = alu_res;
        if (fin) begin
            case (kind_q)
                K_ADD, K_SUMC, K_SUBW: begin
                    acc_d = alu_res;
                    cy_d  = alu_cy;
                    ac_d  = alu_ac;
                    ov_d  = alu_ov;
                end
                K_INC, K_DEC: begin
                    if (src_q == S_ACC) acc_d = alu_res;
                    rf_we = (src_q == S_REG);
                end
                K_MUL: begin
                    acc_d = prod[7:0];
                    b_d   = prod[15:8];
                    cy_d  = 1'b0;
                    ov_d  = |prod[15:8];
                end
                K_DIV: begin
                    cy_d = 1'b0;
                    ov_d = div_zero;      // zero divisor leaves both registers alone
                    if (!div_zero) begin
                        acc_d = quot;
                        b_d   = rem;
                    end
                end
                K_DA: begin
                    acc_d = alu_res;
                    cy_d  = alu_cy;
                end
                K_INCDP: wptr_d = wptr_q + WPTR_STEP;
                K_LDDP:  wptr_d = {opnd_q, oper2_q};
                K_MOVC:  acc_d  = opnd_q;
                K_BIT:   cy_d   = src_val[bitsel_q];
                default: acc_d  = acc_q;
            endcase
        end
    end

    // ready is raised one cycle early so the next instruction issues back to back
    assign ready_d = take ? (dec_ncyc == CYC_REG) :
                     fin  ? 1'b1 :
                     exec ? (el_inc == ncyc_q) : 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // sequencer and memory strobes
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q     <= ST_IDLE;
            kind_q      <= K_BAD;
            src_q       <= S_NONE;
            ncyc_q      <= CYC_REG;
            el_q        <= PH_FIRST;
            opnd_q      <= RST_BYTE;
            oper2_q     <= RST_BYTE;
            idx_q       <= 5'h00;
            bitsel_q    <= 3'h0;
            fetch_q     <= 1'b0;
            from_code_q <= 1'b0;
            ready_q     <= 1'b1;
            done_q      <= 1'b0;
            illegal_q   <= 1'b0;
            mem_addr_q  <= RST_BYTE;
            mem_rd_q    <= 1'b0;
            mem_wr_q    <= 1'b0;
            mem_wdata_q <= RST_BYTE;
            code_addr_q <= RST_WPTR;
            code_rd_q   <= 1'b0;
        end else begin
            done_q    <= fin;
            illegal_q <= fin && (kind_q == K_BAD);
            mem_rd_q  <= take && dec_fetch && !dec_movc;
            code_rd_q <= take && dec_movc;
            mem_wr_q  <= rmw_wr;
            ready_q   <= ready_d;
            if (exec) el_q <= el_inc;
            if (fin) state_q <= ST_IDLE;
            if (fetch_ph) opnd_q <= fetch_data;
            // step on a memory operand writes back to the same address
            if (rmw_wr) mem_wdata_q <= alu_res;
            if (take) begin
                state_q     <= ST_EXEC;
                kind_q      <= dec_kind;
                src_q       <= dec_src;
                ncyc_q      <= dec_ncyc;
                el_q        <= PH_FIRST;
                opnd_q      <= oper1_i;
                oper2_q     <= oper2_i;
                idx_q       <= rf_index(bank_sel_i, opcode_i[2:0]);
                bitsel_q    <= oper1_i[2:0];
                fetch_q     <= dec_fetch;
                from_code_q <= dec_movc;
                if (dec_fetch && !dec_movc) mem_addr_q <= dat_addr;
                if (dec_movc) code_addr_q <= idx_addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator, b, pointer and flags
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            acc_q  <= RST_BYTE;
            b_q    <= RST_BYTE;
            wptr_q <= RST_WPTR;
            cy_q   <= 1'b0;
            ac_q   <= 1'b0;
            ov_q   <= 1'b0;
        end else begin
            acc_q  <= acc_d;
            b_q    <= b_d;
            wptr_q <= wptr_d;
            cy_q   <= cy_d;
            ac_q   <= ac_d;
            ov_q   <= ov_d;
        end
    end

    // banked working registers, one write port
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            for (int i = 0; i < RF_DEPTH; i++) rf_q[i] <= RST_BYTE;
        end else if (rf_we) begin
            rf_q[idx_q] <= rf_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from flops
    assign inst_ready_o = ready_q;
    assign done_o       = done_q;
    assign illegal_o    = illegal_q;
    assign mem_addr_o   = mem_addr_q;
    assign mem_rd_o     = mem_rd_q;
    assign mem_wr_o     = mem_wr_q;
    assign mem_wdata_o  = mem_wdata_q;
    assign code_addr_o  = code_addr_q;
    assign code_rd_o    = code_rd_q;
    assign acc_o        = acc_q;
    assign b_o          = b_q;
    assign wptr_o       = wptr_q;
    assign carry_o      = cy_q;
    assign aux_carry_o  = ac_q;
    assign overflow_o   = ov_q;
endmodule : cpu_arith_core
`default_nettype wire

// file: rtl/cpu_arith_pkg.sv
// shared constants, opcode decode and cycle tables for the arithmetic core
// assumes one clock and an 8-bit accumulator datapath; no software registers
package cpu_arith_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // operation kinds
    localparam logic [3:0] K_ADD   = 4'h0;
    localparam logic [3:0] K_SUMC  = 4'h1; // sum_with_carry_op
    localparam logic [3:0] K_SUBW  = 4'h2; // minus_with_borrow_op
    localparam logic [3:0] K_INC   = 4'h3;
    localparam logic [3:0] K_DEC   = 4'h4; // step_down_op
    localparam logic [3:0] K_MUL   = 4'h5; // product_op
    localparam logic [3:0] K_DIV   = 4'h6;
    localparam logic [3:0] K_DA    = 4'h7; // bcd_fixup_op
    localparam logic [3:0] K_INCDP = 4'h8;
    localparam logic [3:0] K_LDDP  = 4'h9;
    localparam logic [3:0] K_MOVC  = 4'ha;
    localparam logic [3:0] K_BIT   = 4'hb;
    localparam logic [3:0] K_BAD   = 4'hf;

    // operand source modes
    localparam logic [2:0] S_REG  = 3'h0;
    localparam logic [2:0] S_DIR  = 3'h1;
    localparam logic [2:0] S_IND  = 3'h2;
    localparam logic [2:0] S_IMM  = 3'h3;
    localparam logic [2:0] S_ACC  = 3'h4;
    localparam logic [2:0] S_NONE = 3'h5;

    ////////////////////////////////////////////////////////////////////////////
    // opcodes: group high nibbles and single encodings
    localparam logic [3:0] HI_INC   = 4'h0;
    localparam logic [3:0] HI_DEC   = 4'h1;
    localparam logic [3:0] HI_ADD   = 4'h2;
    localparam logic [3:0] HI_SUMC  = 4'h3;
    localparam logic [3:0] HI_SUBW  = 4'h9;
    localparam logic [3:0] LO_FIRST = 4'h4; // lowest low nibble of a group
    localparam logic [3:0] LO_DIR   = 4'h5;
    localparam logic [3:0] LO_REG   = 4'h8;
    localparam logic [7:0] OPC_MUL   = 8'ha4;
    localparam logic [7:0] OPC_DIV   = 8'h84;
    localparam logic [7:0] OPC_DA    = 8'hd4;
    localparam logic [7:0] OPC_INCDP = 8'ha3;
    localparam logic [7:0] OPC_LDDP  = 8'h90;
    localparam logic [7:0] OPC_MOVC  = 8'h93;
    localparam logic [7:0] OPC_BITC  = 8'ha2;

    ////////////////////////////////////////////////////////////////////////////
    // cycles per instruction and pipeline phases
    localparam logic [2:0] CYC_REG    = 3'd1;
    localparam logic [2:0] CYC_MEM    = 3'd2;
    localparam logic [2:0] CYC_INCREG = 3'd2;
    localparam logic [2:0] CYC_RMW    = 3'd3;
    localparam logic [2:0] CYC_MUL    = 3'd2;
    localparam logic [2:0] CYC_DIV    = 3'd6;
    localparam logic [2:0] CYC_DA     = 3'd3;
    localparam logic [2:0] CYC_LDDP   = 3'd3;
    localparam logic [2:0] CYC_MOVC   = 3'd5;
    localparam logic [2:0] CYC_BIT    = 3'd2;
    localparam logic [2:0] PH_FIRST   = 3'd1;
    localparam logic [2:0] PH_FETCH   = 3'd2; // edge at which read data is taken

    ////////////////////////////////////////////////////////////////////////////
    // storage, reset values, misc constants
    localparam int         RF_DEPTH     = 32; // four banks of eight
    localparam logic [7:0] RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_WPTR    = 16'h0000;
    localparam logic [15:0] WPTR_STEP   = 16'h0001;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] BCD_MAX      = 8'h09;
    localparam logic [8:0] BCD_LO_ADJ   = 9'h006;
    localparam logic [8:0] BCD_HI_ADJ   = 9'h060;

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic [3:0] op_kind(input logic [7:0] opc);
        logic [3:0] k;
        k = K_BAD;
        if (opc == OPC_MUL) k = K_MUL;
        else if (opc == OPC_DIV) k = K_DIV;
        else if (opc == OPC_DA) k = K_DA;
        else if (opc == OPC_INCDP) k = K_INCDP;
        else if (opc == OPC_LDDP) k = K_LDDP;
        else if (opc == OPC_MOVC) k = K_MOVC;
        else if (opc == OPC_BITC) k = K_BIT;
        else if (opc[3:0] >= LO_FIRST) begin
            case (opc[7:4])
                HI_INC:  k = K_INC;
                HI_DEC:  k = K_DEC;
                HI_ADD:  k = K_ADD;
                HI_SUMC: k = K_SUMC;
                HI_SUBW: k = K_SUBW;
                default: k = K_BAD;
            endcase
        end
        return k;
    endfunction : op_kind

    function automatic logic [2:0] src_mode(input logic [7:0] opc);
        logic [3:0] k;
        logic [2:0] s;
        k = op_kind(opc);
        s = S_NONE;
        if (k == K_BIT) s = S_DIR;
        else if (k <= K_DEC) begin
            if (opc[3:0] >= LO_REG) s = S_REG;
            else if (opc[3:0] > LO_DIR) s = S_IND;
            else if (opc[3:0] == LO_DIR) s = S_DIR;
            else s = (k == K_INC || k == K_DEC) ? S_ACC : S_IMM;
        end
        return s;
    endfunction : src_mode

    function automatic logic [2:0] cycles_of(input logic [3:0] k, input logic [2:0] s);
        logic [2:0] n;
        case (k)
            K_ADD, K_SUMC, K_SUBW: n = (s == S_REG) ? CYC_REG : CYC_MEM;
            K_INC, K_DEC: n = (s == S_ACC) ? CYC_REG : (s == S_REG) ? CYC_INCREG : CYC_RMW;
            K_MUL:   n = CYC_MUL;
            K_DIV:   n = CYC_DIV;
            K_DA:    n = CYC_DA;
            K_LDDP:  n = CYC_LDDP;
            K_MOVC:  n = CYC_MOVC;
            K_BIT:   n = CYC_BIT;
            default: n = CYC_REG;
        endcase
        return n;
    endfunction : cycles_of

    // bit address to byte address: low half sits in bit ram, high half in special register bytes
    function automatic logic [7:0] bit_byte_addr(input logic [7:0] b);
        return b[7] ? {b[7:3], 3'h0} : (BIT_RAM_BASE + {4'h0, b[6:3]});
    endfunction : bit_byte_addr

    function automatic logic [4:0] rf_index(input logic [1:0] bank, input logic [2:0] idx);
        return {bank, idx};
    endfunction : rf_index

endpackage : cpu_arith_pkg

// file: rtl/mul_div_unit.sv
// 8x8 product and 8/8 quotient with remainder
// assumes operands stay stable until the sequencer takes the result
`timescale 1ns/1ns
`default_nettype none
module mul_div_unit (
    // operands
    input  wire logic [7:0]  a_i,
    input  wire logic [7:0]  b_i,
    // results
    output logic      [15:0] prod_o,
    output logic      [7:0]  quot_o,
    output logic      [7:0]  rem_o,
    output logic             div_zero_o
);
    ////////////////////////////////////////////////////////////////////////////
    // one wide combinational array; the sequencer spends the cycle budget on it
    assign prod_o     = {8'h00, a_i} * {8'h00, b_i};
    assign div_zero_o = (b_i == 8'h00);
    // guard the divider outputs so a zero divisor yields zero quotient and remainder
    assign quot_o     = div_zero_o ? 8'h00 : (a_i / b_i);
    assign rem_o      = div_zero_o ? 8'h00 : (a_i % b_i);
endmodule : mul_div_unit
`default_nettype wire

// file: testbench/cpu_arith_chk.sv
// checker: cycle counts and operand addressing at the core's ports
// assumes one clock; bound to every core instance
`timescale 1ns/1ns
`default_nettype none
module cpu_arith_chk (
    // watched ports
    input wire logic        clk_i,
    input wire logic        srst_i,
    input wire logic        inst_valid_i,
    input wire logic        inst_ready_o,
    input wire logic        done_o,
    input wire logic        mem_rd_o,
    input wire logic        mem_wr_o,
    input wire logic        code_rd_o,
    input wire logic [7:0]  opcode_i,
    input wire logic [7:0]  oper1_i,
    input wire logic [7:0]  mem_addr_o,
    input wire logic [7:0]  acc_o,
    input wire logic [15:0] code_addr_o,
    input wire logic [15:0] wptr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);
    logic tk;
    // offer taken at this edge
    assign tk = inst_valid_i && inst_ready_o;
    ////////////////////////////////////////
    a_dir_read: assert property (
        tk && opcode_i == 8'h25 |=> mem_rd_o && mem_addr_o == $past(oper1_i)) else $error("bad read");
    a_reg_fast: assert property (
        tk && opcode_i[7:3] == 5'h05 |=> inst_ready_o ##1 done_o) else $error("reg add slow");
    a_sumc_two: assert property (
        tk && opcode_i == 8'h34 |-> ##3 done_o) else $error("sum_with_carry_op cycles");
    a_subw_two: assert property (
        tk && opcode_i == 8'h94 |-> ##2 !done_o ##1 done_o) else $error("minus_with_borrow_op cycles");
    a_mul_two: assert property (
        tk && opcode_i == 8'ha4 |-> ##2 !done_o ##1 done_o) else $error("mul cycles");
    a_div_busy: assert property (
        tk && opcode_i == 8'h84 |=> !inst_ready_o [*5] ##1 inst_ready_o ##1 done_o)
        else $error("div cycles");
    a_movc_index: assert property (
        tk && opcode_i == 8'h93 |=> code_rd_o && code_addr_o == wptr_o + {8'h00, acc_o})
        else $error("bad code address");
    a_inc_write: assert property (
        tk && opcode_i == 8'h05 |-> ##3 mem_wr_o && mem_addr_o == $past(oper1_i, 3))
        else $error("bad write back");
endmodule : cpu_arith_chk
bind cpu_arith_core cpu_arith_chk cpu_arith_chk_i (.*);
`default_nettype wire

// file: testbench/cpu_arith_core_test.sv
// bench: hand-written scenarios, each judged before it returns
// assumes mem_model as far side and the checker bound to the core
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module cpu_arith_core_test;
    logic        clk_i = 1'b0, srst_i = 1'b1, inst_valid_i = 1'b0;
    logic [7:0]  opcode_i = 8'h00, oper1_i = 8'h00, oper2_i = 8'h00, mem_rdata_i, code_rdata_i;
    logic [1:0]  bank_sel_i = 2'h0;
    logic        inst_ready_o, done_o, illegal_o, mem_rd_o, mem_wr_o, code_rd_o;
    logic        carry_o, aux_carry_o, overflow_o;
    logic [7:0]  mem_addr_o, mem_wdata_o, acc_o, b_o;
    logic [15:0] code_addr_o, wptr_o;
    int          num_errors = 0, cmp_count = 0;
    cpu_arith_core cpu_arith_core_i (.*);
    mem_model mem_model_i (.clk_i(clk_i), .rd_i(mem_rd_o), .wr_i(mem_wr_o), .crd_i(code_rd_o),
        .addr_i(mem_addr_o), .wdata_i(mem_wdata_o), .caddr_i(code_addr_o),
        .rdata_o(mem_rdata_i), .cdata_o(code_rdata_i));
    initial forever #4 clk_i = ~clk_i;
    ////////////////////////////////////////
    // issue one instruction, then count edges until done; bounded wait
    task automatic run(input logic [7:0] op, input logic [7:0] o1, input int n,
        input logic [7:0] o2 = 8'h00, input logic [1:0] bk = 2'h0, input logic il = 1'b0);
        int k;
        @(posedge clk_i);
        opcode_i <= op;
        oper1_i <= o1;
        oper2_i <= o2;
        bank_sel_i <= bk;
        inst_valid_i <= 1'b1;
        @(posedge clk_i);
        inst_valid_i <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (done_o !== 1'b1 && k < 20);
        `CHK(k, n + 1)
        `CHK(illegal_o, il)
        if (k >= 20) stop_test();
    endtask : run
    task automatic test_add();
        run(8'h24, 8'h7f, 2);
        run(8'h24, 8'h01, 2);
        `CHK({acc_o, overflow_o, aux_carry_o}, 10'h203)
        run(8'h94, 8'h81, 2);
        `CHK({acc_o, carry_o}, 9'h1ff)
        run(8'h34, 8'h00, 2);
        `CHK({acc_o, carry_o}, 9'h001)
        run(8'h25, 8'h10, 2);
        `CHK(acc_o, 8'h2c)
        $display("test add done");
    endtask : test_add
    task automatic test_reg();
        run(8'h08, 8'h00, 2, 8'h00, 2'h1);
        run(8'h28, 8'h00, 1, 8'h00, 2'h1);
        `CHK(acc_o, 8'h2d)
        run(8'h26, 8'h00, 2, 8'h00, 2'h1);
        `CHK(acc_o, 8'h6a)
        run(8'ha4, 8'h00, 2);
        `CHK({b_o, acc_o, overflow_o}, 17'h00000)
        run(8'h84, 8'h00, 6);
        `CHK({acc_o, overflow_o, carry_o}, 10'h002)
        $display("test reg done");
    endtask : test_reg
    task automatic test_ptr();
        run(8'h90, 8'h12, 3, 8'h34);
        `CHK(wptr_o, 16'h1234)
        run(8'h93, 8'h00, 5);
        `CHK(acc_o, 8'h91)
        run(8'h05, 8'h40, 3);
        `CHK(mem_model_i.ram[8'h40], 8'h7d)
        run(8'h04, 8'h00, 1);
        `CHK(acc_o, 8'h92)
        run(8'ha2, 8'h0b, 2);
        `CHK(carry_o, 1'b1)
        run(8'h14, 8'h00, 1);
        `CHK(acc_o, 8'h91)
        // bcd fixup with aux carry set from an earlier sum and carry set by the bit test
        run(8'hd4, 8'h00, 3);
        `CHK({acc_o, carry_o}, 9'h1ef)
        run(8'ha3, 8'h00, 1);
        `CHK(wptr_o, 16'h1235)
        run(8'ha5, 8'h00, 1, 8'h00, 2'h0, 1'b1);
        `CHK(acc_o, 8'hf7)
        $display("test ptr done");
    endtask : test_ptr
    task automatic stop_test();
        $display("compares=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    // reset two cycles, then the scenarios in order
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        test_add();
        test_reg();
        test_ptr();
        stop_test();
    end
endmodule : cpu_arith_core_test
`default_nettype wire

// file: testbench/mem_model.sv
// far side: ram/special register data space and code memory, answering one cycle after a strobe
// assumes the core's read and write strobes are one cycle wide
`timescale 1ns/1ns
`default_nettype none
module mem_model (
    // strobes, addresses and answers
    input  wire logic        clk_i,
    input  wire logic        rd_i,
    input  wire logic        wr_i,
    input  wire logic        crd_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [15:0] caddr_i,
    output logic      [7:0]  rdata_o = 8'h00,
    output logic      [7:0]  cdata_o = 8'h00
);
    logic [7:0] ram [256];
    // preset pattern so every byte differs from its neighbours
    initial for (int i = 0; i < 256; i++) ram[i] = 8'(i) ^ 8'h3c;
    // stale data is inverted every idle cycle, so a sample one cycle late cannot match by chance
    always @(posedge clk_i) begin
        if (wr_i) ram[addr_i] <= wdata_i;
        rdata_o <= rd_i ? ram[addr_i] : ~rdata_o;
        cdata_o <= crd_i ? caddr_i[7:0] ^ 8'ha5 : ~cdata_o;
    end
endmodule : mem_model
`default_nettype wire
